// File: rtl/ccs_map.svh
// Constants for the charger control sequencer
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
`define CCS_CLK_HZ 200000000
`define CCS_CONV_TIME_MS 1000
`define CCS_CONV_PERIOD_MS 1000
`define CCS_BLINK_HZ 1
`define CCS_BOOST_TYPE 3'h7
`define CCS_TYPE_NONE 3'h0
`define CCS_PH_OFF 2'h0
`define CCS_PH_PRE 2'h1
`define CCS_PH_FAST 2'h2
`define CCS_PH_DONE 2'h3
`define CCS_FLT_NONE 2'h0
`define CCS_FLT_TIMER 2'h3
`define CCS_TMR_5H 2'h0
`define CCS_TMR_8H 2'h1
`define CCS_TMR_12H 2'h2
`define CCS_TMR_20H 2'h3
`define CCS_TMR_DEF 2'h2
`define CCS_VREG_MV 16'h1070
`define CCS_ICHG_MA 16'h0800
`define CCS_IPRE_MA 16'h0080
`define CCS_ITERM_MA 16'h0100
`define CCS_VLIM_DEF 7'h12
`define CCS_IRQ_PULSE 4'h8
`endif

// File: rtl/ccs_pkg.sv
// Types for the charger control sequencer
package ccs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_DETECT, ST_LIMITS, ST_RUN
    } ccs_pwr_t;
    typedef enum logic [1:0] {
        CH_OFF, CH_PRE, CH_FAST, CH_DONE
    } ccs_chg_t;
    typedef struct packed {
        logic [15:0] vreg_mv;
        logic [15:0] ichg_ma;
        logic [15:0] ipre_ma;
        logic [15:0] iterm_ma;
    } ccs_params_t;
    typedef struct packed {
        logic vsys_min;
        logic vlim_active;
        logic current_limit_pin_active;
        logic therm_reg;
    } ccs_reg_flags_t;
endpackage

// File: rtl/ccs_sync.sv
// Two-flop synchroniser bank
`timescale 1ns/100ps
module ccs_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,          // System clock
    input wire logic rst_n_i,        // Async reset, active low
    input wire logic [W-1:0] d_i,    // Asynchronous inputs
    output logic [W-1:0] q_o         // Synchronised outputs
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// File: rtl/ccs_top.sv
// Charger control sequencer top
`timescale 1ns/100ps
`include "ccs_map.svh"
module ccs_top #(
    parameter int CLK_HZ = `CCS_CLK_HZ,
    parameter longint HOUR_CYC = 64'd720000000000,
    parameter int CONV_CYC = (`CCS_CLK_HZ / 1000) * `CCS_CONV_TIME_MS,
    parameter int PERIOD_CYC = (`CCS_CLK_HZ / 1000) * `CCS_CONV_PERIOD_MS,
    parameter int BLINK_CYC = `CCS_CLK_HZ / (2 * `CCS_BLINK_HZ),
    parameter int WD_UNIT_CYC = `CCS_CLK_HZ
) (
    input wire logic CLK_SYS_I,                 // System clock 200 MHz
    input wire logic RST_N_I,                   // Async reset, active low
    input wire logic SRC_PLUGGED_I,             // Input source attached (pin)
    input wire logic REGULATOR_UP_I,            // Internal regulator powered (pin)
    input wire logic SRC_GOOD_I,                // Source qualified good (pin)
    input wire logic CHG_EN_N_I,                // Charge enable pin, active low
    input wire logic BOOST_MODE_I,              // Boost mode active (pin)
    input wire logic VSYS_MIN_I,                // System held at minimum (analog)
    input wire logic VLIM_REG_I,                // Input voltage limit regulating
    input wire logic CURRENT_LIMIT_PIN_REG_I,                // Input current limit regulating
    input wire logic THERM_REG_I,               // Thermal regulation active
    input wire logic BATT_LOW_I,                // Battery below precharge level
    input wire logic BELOW_TERM_I,              // Charge current below termination
    input wire logic ABOVE_RECHG_I,             // Battery above recharge threshold
    input wire logic CHG_FAULT_I,               // Charging fault condition
    input wire logic DET_DONE_I,                // Detection circuit finished (pin)
    input wire logic [2:0] DET_TYPE_I,          // Detected source type
    input wire logic [6:0] ALG_VLIM_I,          // Algorithm voltage limit value
    input wire logic [5:0] PIN_CURRENT_LIMIT_PIN_I,          // Limit from current limit pin
    input wire logic [5:0] CURRENT_LIMIT_PIN_SET_I,          // input_current_limit_setting
    input wire logic ADAPTIVE_EN_I,             // adaptive_input_limit enable
    input wire logic [5:0] ADAPTIVE_CURRENT_LIMIT_PIN_I,     // Adaptive limit result
    input wire logic AUTO_DET_EN_I,             // auto_source_detect_en
    input wire logic FORCE_DET_SET_I,           // Host sets force_source_detect
    input wire logic VLIM_METHOD_I,             // input_voltage_limit_method
    input wire logic VLIM_WR_I,                 // Host write strobe to voltage limit
    input wire logic [6:0] VLIM_WDATA_I,        // Host voltage limit data
    input wire logic [2:0] BOOST_CURRENT_LIMIT_I,         // boost_current_limit
    input wire logic CHG_EN_BIT_I,              // charge_enable_bit
    input wire logic STATE_PIN_DIS_I,           // state_pin_disable
    input wire logic TERM_EN_I,                 // termination_enable
    input wire logic TIMER_EN_I,                // Safety timer enable
    input wire logic SLOWDOWN_EN_I,             // timer_slowdown_enable
    input wire logic [1:0] TIMER_LEN_I,         // safety_timer_length
    input wire logic HOST_WRITE_I,              // Any host write, one pulse
    input wire logic HOST_KICK_I,               // host_timer_kick pulse
    input wire logic [7:0] WD_PERIOD_I,         // Watchdog seconds, 0 disables
    input wire logic CONV_GO_SET_I,             // Host sets monitor_convert_go
    input wire logic MON_CONT_I,                // monitor_continuous_sel
    output logic INPUT_PRESENT_O,               // input_present_flag
    output logic FORCE_DET_O,                   // force_source_detect readback
    output logic DET_RUN_O,                     // Detection running
    output logic [2:0] SRC_TYPE_O,              // Input type status
    output logic [5:0] CURRENT_LIMIT_PIN_EFF_O,              // Effective input current limit
    output logic [6:0] VLIM_O,                  // input_voltage_limit
    output logic ALG_EN_O,                      // Threshold algorithm enabled
    output logic CONV_EN_O,                     // Converter enable
    output logic BATT_SW_O,                     // battery_switch on
    output logic [2:0] BOOST_CURRENT_LIMIT_O,             // Boost limit to power stage
    output logic MIN_SYS_O,                     // min_system_reg_flag
    output logic VLIM_ACT_O,                    // voltage_limit_active_flag
    output logic CURRENT_LIMIT_PIN_ACT_O,                    // current_limit_active_flag
    output ccs_pkg::ccs_params_t PARAMS_O,      // Default charge parameters
    output logic [1:0] PHASE_O,                 // charge_phase_status
    output logic [1:0] FAULT_O,                 // charge_fault_code
    output logic STAT_O,                        // State pin output
    output logic STAT_OE_O,                     // State pin drive enable
    output logic HOST_TIMEOUT_O,                // High in default mode
    output logic CONV_GO_O,                     // monitor_convert_go readback
    output logic ADC_START_O,                   // Conversion running
    output logic INT_N_O                        // Interrupt, active low
);
    logic [11:0] sync_q;
    logic plugged, reg_up, src_good, chg_en_n, det_done, boost_s;
    logic vsys_s, vlim_s, current_limit_pin_s, therm_s, batlow_s, bterm_s, arech_s, fault_s;
    ccs_sync #(.W(12)) u_sync (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .d_i({SRC_PLUGGED_I, REGULATOR_UP_I, SRC_GOOD_I, CHG_EN_N_I, DET_DONE_I,
              BOOST_MODE_I, VSYS_MIN_I, VLIM_REG_I, CURRENT_LIMIT_PIN_REG_I, THERM_REG_I,
              BATT_LOW_I, BELOW_TERM_I}),
        .q_o(sync_q)
    );
    assign {plugged, reg_up, src_good, chg_en_n, det_done, boost_s,
            vsys_s, vlim_s, current_limit_pin_s, therm_s, batlow_s, bterm_s} = sync_q;
    logic [1:0] sync2_q;
    ccs_sync #(.W(2)) u_sync2 (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .d_i({ABOVE_RECHG_I, CHG_FAULT_I}),
        .q_o(sync2_q)
    );
    assign {arech_s, fault_s} = sync2_q;

    function automatic logic [63:0] hours_for(input logic [1:0] code);
        unique case (code)
            `CCS_TMR_5H: hours_for = 64'd5;
            `CCS_TMR_8H: hours_for = 64'd8;
            `CCS_TMR_12H: hours_for = 64'd12;
            `CCS_TMR_20H: hours_for = 64'd20;
        endcase
    endfunction

    // Power-up sequencing
    ccs_pkg::ccs_pwr_t pwr_reg;
    logic force_reg, det_pend, good_d_reg, plug_d_reg;
    logic [2:0] type_reg;
    wire plug_rise = plugged & ~plug_d_reg;
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pwr_reg <= ccs_pkg::ST_IDLE;
            det_pend <= 1'b0;
            plug_d_reg <= 1'b0;
        end else begin
            plug_d_reg <= plugged;
            if (plug_rise)
                det_pend <= AUTO_DET_EN_I;
            unique case (pwr_reg)
                ccs_pkg::ST_IDLE: if (plugged && reg_up) begin
                    // First plug edge must count before det_pend has landed
                    pwr_reg <= (det_pend || (plug_rise && AUTO_DET_EN_I) || force_reg)
                        ? ccs_pkg::ST_DETECT : ccs_pkg::ST_LIMITS;
                end
                ccs_pkg::ST_DETECT: if (det_done) begin
                    pwr_reg <= ccs_pkg::ST_LIMITS;
                    det_pend <= 1'b0;
                end
                ccs_pkg::ST_LIMITS: pwr_reg <= ccs_pkg::ST_RUN;
                ccs_pkg::ST_RUN: begin
                    if (!plugged)
                        pwr_reg <= ccs_pkg::ST_IDLE;
                    else if (force_reg)
                        pwr_reg <= ccs_pkg::ST_DETECT;
                end
                default: pwr_reg <= ccs_pkg::ST_IDLE;
            endcase
        end
    end
    wire det_run = (pwr_reg == ccs_pkg::ST_DETECT);
    wire det_finish = det_run & det_done;

    // Force detect: set wins over self-clear
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I)
            force_reg <= 1'b0;
        else if (FORCE_DET_SET_I)
            force_reg <= 1'b1;
        else if (det_finish)
            force_reg <= 1'b0;
    end
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I)
            type_reg <= `CCS_TYPE_NONE;
        else if (!plugged)
            type_reg <= `CCS_TYPE_NONE;
        else if (det_finish)
            type_reg <= DET_TYPE_I;
    end

    // Input voltage limit register
    logic [6:0] vlim_reg;
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I)
            vlim_reg <= `CCS_VLIM_DEF;
        else if (VLIM_METHOD_I && VLIM_WR_I)
            vlim_reg <= VLIM_WDATA_I;
        else if (!VLIM_METHOD_I)
            vlim_reg <= ALG_VLIM_I;
    end

    // Charge cycle
    ccs_pkg::ccs_chg_t chg_reg;
    logic chg_allow_reg, timer_exp, term_evt;
    wire in_reg = vlim_s | current_limit_pin_s | therm_s;
    wire chg_on = CHG_EN_BIT_I & chg_allow_reg & (pwr_reg == ccs_pkg::ST_RUN) & ~boost_s;
    assign term_evt = (chg_reg == ccs_pkg::CH_FAST) & bterm_s & arech_s & TERM_EN_I
                    & ~in_reg;
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I)
            chg_allow_reg <= 1'b0;
        else
            chg_allow_reg <= ~chg_en_n;
    end
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            chg_reg <= ccs_pkg::CH_OFF;
        end else if (!chg_on || timer_exp) begin
            chg_reg <= ccs_pkg::CH_OFF;
        end else begin
            unique case (chg_reg)
                ccs_pkg::CH_OFF: chg_reg <= batlow_s ? ccs_pkg::CH_PRE : ccs_pkg::CH_FAST;
                ccs_pkg::CH_PRE: if (!batlow_s) chg_reg <= ccs_pkg::CH_FAST;
                ccs_pkg::CH_FAST: if (term_evt) chg_reg <= ccs_pkg::CH_DONE;
                ccs_pkg::CH_DONE: if (!arech_s) chg_reg <= ccs_pkg::CH_FAST;
            endcase
        end
    end
    wire charging = (chg_reg == ccs_pkg::CH_PRE) | (chg_reg == ccs_pkg::CH_FAST);

    // Safety timer in hours, counted at half rate (every other cycle) under slowdown
    logic [63:0] tmr_cnt;
    logic tmr_half;
    logic [1:0] fault_reg;
    wire slow = in_reg & SLOWDOWN_EN_I;
    wire [63:0] tmr_lim = hours_for(TIMER_LEN_I) * HOUR_CYC;
    assign timer_exp = TIMER_EN_I & charging & (tmr_cnt >= tmr_lim);
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tmr_cnt <= '0;
            tmr_half <= 1'b0;
        end else if (!charging || !TIMER_EN_I) begin
            tmr_cnt <= '0;
            tmr_half <= 1'b0;
        end else begin
            tmr_half <= ~tmr_half;
            if (!slow || tmr_half)
                tmr_cnt <= tmr_cnt + 64'd1;
        end
    end
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I)
            fault_reg <= `CCS_FLT_NONE;
        else if (timer_exp)
            fault_reg <= `CCS_FLT_TIMER;
        else if (!CHG_EN_BIT_I)
            fault_reg <= `CCS_FLT_NONE;
    end

    // State pin blink
    logic [31:0] blink_cnt;
    logic blink_reg;
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            blink_cnt <= '0;
            blink_reg <= 1'b0;
        end else if (blink_cnt >= 32'(BLINK_CYC - 1)) begin
            blink_cnt <= '0;
            blink_reg <= ~blink_reg;
        end else begin
            blink_cnt <= blink_cnt + 32'd1;
        end
    end
    wire faulted = fault_s | (fault_reg != `CCS_FLT_NONE);

    // Watchdog, host and default mode
    logic host_mode_reg;
    logic [39:0] wd_cnt;
    wire [39:0] wd_lim = 40'(WD_PERIOD_I) * 40'(WD_UNIT_CYC);
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            host_mode_reg <= 1'b0;
            wd_cnt <= '0;
        end else if (HOST_WRITE_I || HOST_KICK_I || WD_PERIOD_I == 8'h00) begin
            host_mode_reg <= host_mode_reg | HOST_WRITE_I;
            wd_cnt <= '0;
        end else if (host_mode_reg) begin
            if (wd_cnt >= wd_lim - 40'd1) begin
                host_mode_reg <= 1'b0;
                wd_cnt <= '0;
            end else begin
                wd_cnt <= wd_cnt + 40'd1;
            end
        end
    end

    // Battery monitor
    logic go_reg, busy_reg;
    logic [31:0] conv_cnt, per_cnt;
    wire per_tick = MON_CONT_I & (per_cnt >= 32'(PERIOD_CYC - 1));
    wire conv_end = busy_reg & (conv_cnt >= 32'(CONV_CYC - 1));
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I)
            per_cnt <= '0;
        else if (!MON_CONT_I || per_tick)
            per_cnt <= '0;
        else
            per_cnt <= per_cnt + 32'd1;
    end
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            go_reg <= 1'b0;
            busy_reg <= 1'b0;
            conv_cnt <= '0;
        end else begin
            if (CONV_GO_SET_I || per_tick)
                go_reg <= 1'b1;
            else if (conv_end)
                go_reg <= 1'b0;
            if (busy_reg) begin
                conv_cnt <= conv_end ? 32'd0 : conv_cnt + 32'd1;
                if (conv_end)
                    busy_reg <= 1'b0;
            end else if (go_reg && !det_run) begin
                busy_reg <= 1'b1;
            end
        end
    end

    // Interrupt pulses, one per event
    logic [3:0] irq_cnt;
    logic [3:0] irq_pend;
    wire good_rise = src_good & ~good_d_reg;
    wire [3:0] irq_evt = {good_rise, term_evt, timer_exp & (fault_reg != `CCS_FLT_TIMER),
                          1'b0};
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            good_d_reg <= 1'b0;
            irq_cnt <= '0;
            irq_pend <= '0;
        end else begin
            good_d_reg <= src_good;
            if (irq_cnt != 4'h0) begin
                irq_cnt <= irq_cnt - 4'h1;
                irq_pend <= irq_pend | irq_evt;
            end else if ((irq_pend | irq_evt) != 4'h0) begin
                irq_cnt <= `CCS_IRQ_PULSE * 4'h1 + 4'h0;
                irq_pend <= ((irq_pend | irq_evt) - 4'h1) & (irq_pend | irq_evt);
            end
        end
    end

    // Registered outputs
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            INPUT_PRESENT_O <= 1'b0;
            SRC_TYPE_O <= `CCS_TYPE_NONE;
            CURRENT_LIMIT_PIN_EFF_O <= '0;
            CONV_EN_O <= 1'b0;
            BATT_SW_O <= 1'b0;
            MIN_SYS_O <= 1'b0;
            VLIM_ACT_O <= 1'b0;
            CURRENT_LIMIT_PIN_ACT_O <= 1'b0;
            PHASE_O <= `CCS_PH_OFF;
            STAT_O <= 1'b1;
            STAT_OE_O <= 1'b0;
        end else begin
            INPUT_PRESENT_O <= src_good;
            SRC_TYPE_O <= boost_s ? `CCS_BOOST_TYPE : type_reg;
            CURRENT_LIMIT_PIN_EFF_O <= (ADAPTIVE_EN_I && ADAPTIVE_CURRENT_LIMIT_PIN_I < CURRENT_LIMIT_PIN_SET_I) ?
                ((ADAPTIVE_CURRENT_LIMIT_PIN_I < PIN_CURRENT_LIMIT_PIN_I) ? ADAPTIVE_CURRENT_LIMIT_PIN_I : PIN_CURRENT_LIMIT_PIN_I) :
                ((CURRENT_LIMIT_PIN_SET_I < PIN_CURRENT_LIMIT_PIN_I) ? CURRENT_LIMIT_PIN_SET_I : PIN_CURRENT_LIMIT_PIN_I);
            CONV_EN_O <= (pwr_reg == ccs_pkg::ST_RUN);
            BATT_SW_O <= (pwr_reg == ccs_pkg::ST_RUN) ? chg_on : 1'b1;
            MIN_SYS_O <= vsys_s;
            VLIM_ACT_O <= vlim_s;
            CURRENT_LIMIT_PIN_ACT_O <= current_limit_pin_s;
            PHASE_O <= (chg_reg == ccs_pkg::CH_PRE) ? `CCS_PH_PRE :
                       (chg_reg == ccs_pkg::CH_FAST) ? `CCS_PH_FAST :
                       (chg_reg == ccs_pkg::CH_DONE) ? `CCS_PH_DONE : `CCS_PH_OFF;
            // Open drain: driving means pulling low
            STAT_O <= 1'b0;
            STAT_OE_O <= ~STATE_PIN_DIS_I & (faulted ? blink_reg : charging);
        end
    end

    assign PARAMS_O = '{vreg_mv: `CCS_VREG_MV, ichg_ma: `CCS_ICHG_MA,
                        ipre_ma: `CCS_IPRE_MA, iterm_ma: `CCS_ITERM_MA};
    assign FORCE_DET_O = force_reg;
    assign DET_RUN_O = det_run;
    assign VLIM_O = vlim_reg;
    assign ALG_EN_O = ~VLIM_METHOD_I;
    assign BOOST_CURRENT_LIMIT_O = BOOST_CURRENT_LIMIT_I;
    assign FAULT_O = fault_reg;
    assign HOST_TIMEOUT_O = ~host_mode_reg;
    assign CONV_GO_O = go_reg;
    assign ADC_START_O = busy_reg;
    assign INT_N_O = (irq_cnt == 4'h0);
endmodule

// File: tb/ccs_host_model.sv
// Host-side model issuing one-cycle control strobes
`timescale 1ns/100ps
module ccs_host_model (
    input wire logic CLK_SYS_I, // System clock
    output logic FORCE_DET_SET_I, // Force detection strobe
    output logic VLIM_WR_I, // Voltage limit write strobe
    output logic HOST_WRITE_I, // Any host write strobe
    output logic HOST_KICK_I, // Watchdog kick strobe
    output logic CONV_GO_SET_I // Conversion start strobe
);
    logic [4:0] strobe_reg = 5'h00;
    assign {CONV_GO_SET_I, HOST_KICK_I, HOST_WRITE_I, VLIM_WR_I, FORCE_DET_SET_I} = strobe_reg;
    // Every bus write also counts as a host access, as a real write would
    task automatic pulse(input int idx);
        @(posedge CLK_SYS_I);
        strobe_reg <= 5'h04 | (5'h01 << idx);
        @(posedge CLK_SYS_I);
        strobe_reg <= 5'h00;
    endtask
endmodule

// File: tb/ccs_props.sv
// Port-level assertions for the charger control sequencer
`timescale 1ns/100ps
module ccs_props (
    input wire logic CLK_SYS_I, RST_N_I, BOOST_MODE_I, VSYS_MIN_I, // Clock, reset, status
    input wire logic [5:0] CURRENT_LIMIT_PIN_SET_I, PIN_CURRENT_LIMIT_PIN_I, CURRENT_LIMIT_PIN_EFF_O, // Current limits
    input wire logic VLIM_METHOD_I, VLIM_WR_I, HOST_WRITE_I, FORCE_DET_SET_I, // Controls
    input wire logic [6:0] VLIM_WDATA_I, ALG_VLIM_I, VLIM_O, // Voltage limits
    input wire logic [2:0] SRC_TYPE_O, // Input type
    input wire logic ALG_EN_O, MIN_SYS_O, HOST_TIMEOUT_O, FORCE_DET_O, INT_N_O, CONV_GO_O // Flags
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    // Five cycles cover the two sync flops plus the output register
    chk_boost_type_code: assert property (BOOST_MODE_I [*5] |-> SRC_TYPE_O == 3'h7)
        else $error("boost type not reported");
    chk_min_sys_flag: assert property (VSYS_MIN_I [*5] |-> MIN_SYS_O)
        else $error("min system flag low");
    chk_current_limit_pin_bound: assert property (RST_N_I |=> CURRENT_LIMIT_PIN_EFF_O <= $past(CURRENT_LIMIT_PIN_SET_I)
        && CURRENT_LIMIT_PIN_EFF_O <= $past(PIN_CURRENT_LIMIT_PIN_I)) else $error("input current limit exceeded");
    chk_alg_method: assert property (ALG_EN_O == !VLIM_METHOD_I)
        else $error("algorithm enable wrong");
    chk_vlim_write: assert property (VLIM_METHOD_I && VLIM_WR_I |=>
        VLIM_O == $past(VLIM_WDATA_I)) else $error("voltage limit write lost");
    // The release edge still shows the reset value, so it is left out
    chk_vlim_track: assert property ($past(RST_N_I) && !$past(VLIM_METHOD_I) |->
        VLIM_O == $past(ALG_VLIM_I)) else $error("voltage limit not tracking");
    chk_host_mode_entry: assert property (HOST_WRITE_I |=> !HOST_TIMEOUT_O)
        else $error("host mode not entered");
    chk_force_det_set: assert property (FORCE_DET_SET_I |=> FORCE_DET_O)
        else $error("force detect not set");
    chk_irq_pulse_len: assert property ($fell(INT_N_O) |=> !INT_N_O [*7] ##1 INT_N_O)
        else $error("interrupt pulse length wrong");
    chk_conv_go_hold: assert property ($rose(CONV_GO_O) |=> CONV_GO_O [*8]
        ##[1:40] !CONV_GO_O) else $error("conversion start bit timing wrong");
    cover property ($fell(INT_N_O));
    cover property ($rose(CONV_GO_O));
    cover property (FORCE_DET_O ##1 !FORCE_DET_O);
endmodule
bind ccs_top ccs_props u_props (.*);

// File: tb/tb_top.sv
// Self-checking testbench for the charger control sequencer
`timescale 1ns/100ps
module tb_top;
    logic CLK_SYS_I = 1'b0, RST_N_I = 1'b0, SRC_PLUGGED_I = 1'b0, REGULATOR_UP_I = 1'b0;
    logic SRC_GOOD_I = 1'b0, CHG_EN_N_I = 1'b1, BOOST_MODE_I = 1'b0, VSYS_MIN_I = 1'b0;
    logic VLIM_REG_I = 1'b0, CURRENT_LIMIT_PIN_REG_I = 1'b0, THERM_REG_I = 1'b0, BATT_LOW_I = 1'b0;
    logic BELOW_TERM_I = 1'b0, ABOVE_RECHG_I = 1'b0, CHG_FAULT_I = 1'b0, DET_DONE_I = 1'b0;
    logic ADAPTIVE_EN_I = 1'b0, AUTO_DET_EN_I = 1'b0, VLIM_METHOD_I = 1'b0, CHG_EN_BIT_I = 1'b0;
    logic STATE_PIN_DIS_I = 1'b0, TERM_EN_I = 1'b1, TIMER_EN_I = 1'b1, SLOWDOWN_EN_I = 1'b1;
    logic MON_CONT_I = 1'b0;
    logic [2:0] DET_TYPE_I = 3'h0, BOOST_CURRENT_LIMIT_I = 3'h3, SRC_TYPE_O, BOOST_CURRENT_LIMIT_O;
    logic [1:0] TIMER_LEN_I = 2'h2, PHASE_O, FAULT_O;
    logic [5:0] PIN_CURRENT_LIMIT_PIN_I = 6'h08, CURRENT_LIMIT_PIN_SET_I = 6'h10, ADAPTIVE_CURRENT_LIMIT_PIN_I = 6'h3F, CURRENT_LIMIT_PIN_EFF_O;
    logic [6:0] ALG_VLIM_I = 7'h2A, VLIM_WDATA_I = 7'h55, VLIM_O;
    logic [7:0] WD_PERIOD_I = 8'h00;
    logic FORCE_DET_SET_I, VLIM_WR_I, HOST_WRITE_I, HOST_KICK_I, CONV_GO_SET_I, INPUT_PRESENT_O;
    logic FORCE_DET_O, DET_RUN_O, ALG_EN_O, CONV_EN_O, BATT_SW_O, MIN_SYS_O, VLIM_ACT_O;
    logic CURRENT_LIMIT_PIN_ACT_O, STAT_O, STAT_OE_O, HOST_TIMEOUT_O, CONV_GO_O, ADC_START_O, INT_N_O;
    ccs_pkg::ccs_params_t PARAMS_O;
    int fails = 0;
    int num_checks = 0;
    always #2.5 CLK_SYS_I = ~CLK_SYS_I;
    // Short counts keep the hour timer and watchdog within a brief run
    ccs_top #(.HOUR_CYC(64'd100), .CONV_CYC(20), .PERIOD_CYC(20), .BLINK_CYC(20),
        .WD_UNIT_CYC(20)) u_dut (.*);
    ccs_host_model u_host (.*);
    task automatic end_of_test;
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge CLK_SYS_I);
        @(negedge CLK_SYS_I);
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return FORCE_DET_O;
            1: return CONV_GO_O;
            2: return HOST_TIMEOUT_O;
            default: return FAULT_O == 2'h3;
        endcase
    endfunction
    task automatic wait_for(input int sel, input logic val, input int lim);
        int k;
        for (k = 0; k < lim && pick(sel) !== val; k++) @(negedge CLK_SYS_I);
        if (k == lim) begin
            chk("wait bound", 0, 1);
            end_of_test();
        end
    endtask
    initial begin
        step(5);
        chk("params", 64'h1070_0800_0080_0100, PARAMS_O);
        chk("timeout", 1, HOST_TIMEOUT_O);
        @(posedge CLK_SYS_I);
        RST_N_I <= 1'b1;
        {BOOST_MODE_I, VSYS_MIN_I, VLIM_REG_I, CURRENT_LIMIT_PIN_REG_I, VLIM_METHOD_I} <= 5'h1F;
        step(6);
        chk("src type", 3'h7, SRC_TYPE_O);
        chk("boost_current_limit", 3'h3, BOOST_CURRENT_LIMIT_O);
        chk("dpm flags", 3'h7, {MIN_SYS_O, VLIM_ACT_O, CURRENT_LIMIT_PIN_ACT_O});
        u_host.pulse(1);
        step(2);
        chk("vlim", 7'h55, VLIM_O);
        chk("alg en", 0, ALG_EN_O);
        {BOOST_MODE_I, VSYS_MIN_I, VLIM_REG_I, CURRENT_LIMIT_PIN_REG_I, VLIM_METHOD_I, WD_PERIOD_I} <= 13'h1;
        ALG_VLIM_I <= 7'h2B;
        step(3);
        chk("vlim", 7'h2B, VLIM_O);
        u_host.pulse(4);
        step(10);
        chk("timeout", 0, HOST_TIMEOUT_O);
        chk("conv go", 1, CONV_GO_O);
        wait_for(1, 0, 40);
        wait_for(2, 1, 30);
        {SRC_PLUGGED_I, REGULATOR_UP_I, SRC_GOOD_I, AUTO_DET_EN_I, CHG_EN_BIT_I} <= 5'h1F;
        {CHG_EN_N_I, BATT_LOW_I, DET_TYPE_I} <= 5'hB;
        step(6);
        chk("det run", 1, DET_RUN_O);
        chk("present", 1, INPUT_PRESENT_O);
        DET_DONE_I <= 1'b1;
        step(4);
        chk("src type", 3'h3, SRC_TYPE_O);
        {DET_DONE_I, DET_TYPE_I} <= 4'h5;
        u_host.pulse(0);
        step(1);
        chk("force", 1, FORCE_DET_O);
        DET_DONE_I <= 1'b1;
        wait_for(0, 0, 20);
        step(4);
        chk("src type", 3'h5, SRC_TYPE_O);
        chk("run", 4'hF, {CONV_EN_O, BATT_SW_O, STAT_OE_O, PHASE_O == 2'h1});
        chk("current_limit_pin", 6'h08, CURRENT_LIMIT_PIN_EFF_O);
        {DET_DONE_I, BATT_LOW_I} <= 2'h0;
        step(5);
        chk("phase", 2'h2, PHASE_O);
        {BELOW_TERM_I, ABOVE_RECHG_I} <= 2'h3;
        step(5);
        chk("done", 3'h3, {STAT_OE_O, PHASE_O});
        {ABOVE_RECHG_I, TERM_EN_I, TIMER_LEN_I} <= 4'h0;
        step(5);
        chk("phase", 2'h2, PHASE_O);
        // Thermal regulation with slowdown off must still expire at full rate
        {THERM_REG_I, SLOWDOWN_EN_I} <= 2'h2;
        wait_for(3, 1, 700);
        {ADAPTIVE_EN_I, ADAPTIVE_CURRENT_LIMIT_PIN_I, STATE_PIN_DIS_I} <= {1'b1, 6'h04, 1'b1};
        step(3);
        chk("current_limit_pin stat", {6'h04, 1'b0}, {CURRENT_LIMIT_PIN_EFF_O, STAT_OE_O});
        MON_CONT_I <= 1'b1;
        wait_for(1, 1, 30);
        MON_CONT_I <= 1'b0;
        wait_for(1, 0, 60);
        {CHG_EN_BIT_I, TIMER_EN_I} <= 2'h0;
        step(5);
        chk("off", 5'h0, {BATT_SW_O, PHASE_O, FAULT_O});
        end_of_test();
    end
endmodule
